/* File: dv/banked_local_scratchpad_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module banked_local_scratchpad_tb_top;
	localparam logic [63:0] SZ_W = 64'hAAAA_AAAA_AAAA_AAAA;
	logic          sys_clk;
	logic          sys_rst;
	logic          req_valid;
	logic          req_ready;
	logic          req_write;
	logic [31:0]   req_mask;
	logic [479:0]  req_addr;
	logic [63:0]   req_size;
	logic [1023:0] req_wdata;
	logic          resp_valid;
	logic          resp_write;
	logic [31:0]   resp_lanes;
	logic [1023:0] resp_rdata;
	logic          wave_stall;
	logic [31:0]   stall_cycles;
	logic [31:0]   time_cycles;
	int            err_total;
	int            tests_run;
	int            cyc;
	int            beats;
	int            first_at;
	logic [31:0]   first_lanes;
	logic [31:0]   last_lanes;
	logic [31:0]   rd [32];
	logic          stl;
	logic          wr_seen;
	logic [31:0]   delta;
	logic [479:0]  a;
	logic [1023:0] d;

	banked_local_scratchpad u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_mask(req_mask), .req_addr(req_addr),
		.req_size(req_size), .req_wdata(req_wdata),
		.resp_valid(resp_valid), .resp_write(resp_write),
		.resp_lanes(resp_lanes), .resp_rdata(resp_rdata),
		.wave_stall(wave_stall), .stall_cycles(stall_cycles),
		.time_cycles(time_cycles));
	lane_issuer_model u_issuer (.sys_clk(sys_clk), .req_ready(req_ready),
		.req_valid(req_valid), .req_write(req_write),
		.req_mask(req_mask), .req_addr(req_addr), .req_size(req_size),
		.req_wdata(req_wdata));

	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (err_total == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s exp=%h seen=%h", what, exp, seen);
		end
	endtask : check

	// Offer one window, gather every beat until idle again
	task automatic run(input logic wr, input logic [31:0] mask,
		input logic [63:0] size);
		logic [31:0] s0;
		int n;
		s0 = stall_cycles;
		beats = 0;
		stl = 1'b0;
		n = 0;
		u_issuer.offer(wr, mask, a, size, d);
		while (n < 100) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (wave_stall === 1'b1) stl = 1'b1;
			if (resp_valid === 1'b1) begin
				beats++;
				if (beats == 1) first_at = n;
				if (beats == 1) first_lanes = resp_lanes;
				last_lanes = resp_lanes;
				wr_seen = resp_write;
				for (int s = 0; s < 32; s++)
					if (resp_lanes[s]) rd[s] = resp_rdata[32*s+:32];
			end
			if (beats > 0 && req_ready === 1'b1 && resp_valid !== 1'b1)
				break;
		end
		if (n == 100) check("done", 32'h0, 32'h1);
		delta = stall_cycles - s0;
	endtask : run

	task automatic t_worst_write();
		for (int s = 0; s < 32; s++) a[15*s+:15] = 15'(s * 128);
		for (int s = 0; s < 32; s++) d[32*s+:32] = 32'h5000_0000 | s;
		run(1'b1, 32'hFFFF_FFFF, SZ_W);
		check("worst beats", beats, 32);
		check("worst stall", delta, 31);
		check("worst stalled", {31'h0, stl}, 1);
		check("worst first", first_lanes, 32'h0000_0001);
		check("worst last", last_lanes, 32'h8000_0000);
		check("write flag", wr_seen, 1);
	endtask : t_worst_write

	task automatic t_flat();
		for (int s = 0; s < 32; s++) a[15*s+:15] = 15'(s * 4);
		for (int s = 0; s < 32; s++) d[32*s+:32] = 32'h1234_5600 | s;
		run(1'b1, 32'hFFFF_FFFF, SZ_W);
		check("flat wr beats", beats, 1);
		run(1'b0, 32'hFFFF_FFFF, SZ_W);
		check("flat rd beats", beats, 1);
		check("read flag", wr_seen, 0);
		check("flat lat", first_at, 2);
		check("flat stall", {31'h0, stl}, 0);
		check("flat delta", delta, 0);
		for (int s = 0; s < 32; s++)
			check("flat data", rd[s], 32'h1234_5600 | s);
		a[14:0] = 15'h0000;
		a[29:15] = 15'h0080;
		run(1'b0, 32'h0000_0003, SZ_W);
		check("pair beats", beats, 2);
		check("pair first", first_lanes, 32'h0000_0001);
		check("pair stall", {31'h0, stl}, 1);
		check("pair delta", delta, 1);
		check("pair d0", rd[0], 32'h1234_5600);
		check("pair d1", rd[1], 32'h5000_0001);
	endtask : t_flat

	task automatic t_bcast_narrow();
		for (int s = 0; s < 32; s++) a[15*s+:15] = 15'h0008;
		run(1'b0, 32'hFFFF_FFFF, SZ_W);
		check("bc beats", beats, 1);
		check("bc lanes", last_lanes, 32'hFFFF_FFFF);
		for (int s = 0; s < 32; s++)
			check("bc data", rd[s], 32'h1234_5602);
		a[14:0] = 15'h0001;
		a[29:15] = 15'h0006;
		run(1'b0, 32'h0000_0003, 64'h0000_0000_0000_0004);
		check("nr beats", beats, 1);
		check("nr byte", rd[0], 32'h0000_0056);
		check("nr half", rd[1], 32'h0000_1234);
		d[31:0] = 32'h0000_00AB;
		d[63:32] = 32'h0000_CDEF;
		a[14:0] = 15'h0003;
		run(1'b1, 32'h0000_0003, 64'h0000_0000_0000_0004);
		check("nw beats", beats, 1);
		a[14:0] = 15'h0000;
		a[29:15] = 15'h0004;
		run(1'b0, 32'h0000_0003, SZ_W);
		check("nw byte", rd[0], 32'hAB34_5600);
		check("nw half", rd[1], 32'hCDEF_5601);
	endtask : t_bcast_narrow

	initial begin
		err_total = 0;
		tests_run = 0;
		cyc = 0;
		a = '0;
		d = '0;
		sys_rst = 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
		check("rst ready", req_ready, 0);
		check("rst stall", stall_cycles, 0);
		check("rst time", time_cycles, 0);
		sys_rst = 1'b0;
		@(posedge sys_clk);
		#1;
		check("ready", req_ready, 1);
		check("time", time_cycles, 1);
		t_worst_write();
		t_flat();
		t_bcast_narrow();
		print_verdict();
	end
endmodule : banked_local_scratchpad_tb_top
`default_nettype wire

/* File: dv/lane_issuer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lane_issuer_model (
	input  wire logic          sys_clk,
	input  wire logic          req_ready,
	output logic               req_valid,
	output logic               req_write,
	output logic [31:0]        req_mask,
	output logic [479:0]       req_addr,
	output logic [63:0]        req_size,
	output logic [1023:0]      req_wdata
);
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_mask  = '0;
		req_addr  = '1;
		req_size  = '1;
		req_wdata = '1;
	end
	// Two word slots per lane, one offer
	task automatic offer(input logic wr, input logic [31:0] mask,
		input logic [479:0] addr, input logic [63:0] size,
		input logic [1023:0] wdata);
		@(posedge sys_clk);
		#1;
		req_valid = 1'b1;
		req_write = wr;
		req_mask  = mask;
		req_addr  = addr;
		req_size  = size;
		req_wdata = wdata;
		while (req_ready !== 1'b1) begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		#1;
		// Released mask, address and data lines show inverted values; write and size hold
		req_valid = 1'b0;
		req_mask  = ~mask;
		req_addr  = ~addr;
		req_wdata = ~wdata;
	endtask : offer
endmodule : lane_issuer_model
`default_nettype wire

/* File: verilog/banked_local_scratchpad.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scratchpad_params.svh"
module banked_local_scratchpad #(
	parameter int NUM_BANKS = `SP_BANKS_LARGE,
	parameter int SLOTS     = `SP_LANES * `SP_REQ_PER_LANE,
	parameter int CNT_W     = `SP_CNT_W
) (
	input  wire logic                          sys_clk,
	input  wire logic                          sys_rst,
	input  wire logic                          req_valid,
	output logic                               req_ready,
	input  wire logic                          req_write,
	input  wire logic [SLOTS-1:0]              req_mask,
	input  wire logic [SLOTS*15-1:0]           req_addr,
	input  wire logic [SLOTS*2-1:0]            req_size,
	input  wire logic [SLOTS*`SP_DATA_W-1:0]   req_wdata,
	output logic                               resp_valid,
	output logic                               resp_write,
	output logic      [SLOTS-1:0]              resp_lanes,
	output logic      [SLOTS*`SP_DATA_W-1:0]   resp_rdata,
	output logic                               wave_stall,
	output logic      [CNT_W-1:0]              stall_cycles,
	output logic      [CNT_W-1:0]              time_cycles
);
	localparam int ADDR_W = $clog2(`SP_STORE_BYTES);
	localparam int BANK_W = $clog2(NUM_BANKS);
	localparam int WORD_W = ADDR_W - `SP_OFS_W;
	localparam int ROW_W  = WORD_W - BANK_W;
	localparam int ROWS   = `SP_STORE_BYTES / (`SP_WORD_BYTES * NUM_BANKS);
	localparam int SLOT_W = $clog2(SLOTS);
	localparam int DW     = `SP_DATA_W;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	scratchpad_pkg::sp_state_t state_reg, state_next;
	logic [SLOTS-1:0]        pending_reg, pending_next, served;
	logic                    write_reg;
	logic [SLOTS*ADDR_W-1:0] addr_reg;
	logic [SLOTS*2-1:0]      size_reg;
	logic [SLOTS*DW-1:0]     wdata_reg, route_data;
	logic                    s1_valid_reg, s1_write_reg;
	logic [SLOTS-1:0]        s1_mask_reg;
	logic                    req_ready_reg, resp_valid_reg, resp_write_reg;
	logic [SLOTS-1:0]        resp_lanes_reg;
	logic [SLOTS*DW-1:0]     resp_rdata_reg;
	logic                    wave_stall_reg;
	logic [CNT_W-1:0]        stall_cnt_reg, time_cnt_reg;

	logic [BANK_W-1:0]       slot_bank [SLOTS];
	logic [WORD_W-1:0]       slot_word [SLOTS];
	logic [`SP_OFS_W-1:0]    slot_ofs  [SLOTS];
	logic [1:0]              slot_size [SLOTS];
	logic [DW-1:0]           slot_wd   [SLOTS];
	logic                    gnt_valid [NUM_BANKS];
	logic [SLOT_W-1:0]       gnt_idx   [NUM_BANKS];
	logic [DW-1:0]           bank_q    [NUM_BANKS];
	logic [NUM_BANKS-1:0]    bank_bad;

	wire accept   = req_valid && req_ready_reg;
	wire leftover = |(pending_reg & ~served);
	wire [SLOTS-1:0] low_pend = pending_reg & (~pending_reg + 1'b1);

	function automatic logic [3:0] be_of(input logic [1:0] sz,
		input logic [`SP_OFS_W-1:0] ofs);
		be_of = (sz == `SP_SIZE_BYTE) ? (`SP_BE_BYTE << ofs) :
			(sz == `SP_SIZE_HALF) ? (`SP_BE_HALF << ofs) : `SP_BE_WORD;
	endfunction : be_of

	function automatic logic [DW-1:0] wd_of(input logic [1:0] sz,
		input logic [DW-1:0] d);
		wd_of = (sz == `SP_SIZE_BYTE) ? {4{d[7:0]}} :
			(sz == `SP_SIZE_HALF) ? {2{d[15:0]}} : d;
	endfunction : wd_of

	// Per slot decode and service decision
	genvar s, b;
	generate
		for (s = 0; s < SLOTS; s++) begin : g_slot
			wire [ADDR_W-1:0] a = addr_reg[s*ADDR_W +: ADDR_W];
			wire [BANK_W-1:0] bk = a[`SP_OFS_W +: BANK_W];
			wire [SLOT_W-1:0] w = gnt_idx[bk];
			wire [DW-1:0] q = bank_q[bk] >> {slot_ofs[s], 3'h0};
			assign slot_bank[s] = bk;
			assign slot_word[s] = a[ADDR_W-1:`SP_OFS_W];
			assign slot_ofs[s]  = a[`SP_OFS_W-1:0];
			assign slot_size[s] = size_reg[2*s +: 2];
			assign slot_wd[s]   = wdata_reg[s*DW +: DW];
			// Winner of its bank, or a read of the winner's word
			assign served[s] = pending_reg[s] && gnt_valid[bk] &&
				(w == SLOT_W'(s) || (!write_reg &&
				slot_word[w] == slot_word[s]));
			// Narrow reads cost a full word slot, then are extracted
			assign route_data[s*DW +: DW] =
				(slot_size[s] == `SP_SIZE_BYTE) ? {24'h00_0000, q[7:0]} :
				(slot_size[s] == `SP_SIZE_HALF) ? {16'h0000, q[15:0]} :
				q;
		end
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic [DW-1:0] gw;
			// Lowest pending slot wins the bank each cycle
			always_comb begin
				gnt_valid[b] = 1'b0;
				gnt_idx[b]   = '0;
				for (int i = SLOTS - 1; i >= 0; i--) begin
					if (pending_reg[i] && slot_bank[i] == BANK_W'(b)) begin
						gnt_valid[b] = 1'b1;
						gnt_idx[b]   = SLOT_W'(i);
					end
				end
			end
			always_comb begin
				bank_bad[b] = 1'b0;
				for (int i = 0; i < SLOTS; i++) begin
					if (served[i] && slot_bank[i] == BANK_W'(b) &&
						slot_word[i] != slot_word[gnt_idx[b]]) begin
						bank_bad[b] = 1'b1;
					end
				end
			end
			assign gw = wd_of(slot_size[gnt_idx[b]], slot_wd[gnt_idx[b]]);
			scratchpad_bank #(
				.DEPTH (ROWS),
				.ROW_W (ROW_W)
			) u_bank (
				.sys_clk (sys_clk),
				.en      (gnt_valid[b]),
				.we      (write_reg),
				.be      (be_of(slot_size[gnt_idx[b]], slot_ofs[gnt_idx[b]])),
				.row     (slot_word[gnt_idx[b]][WORD_W-1:BANK_W]),
				.wdata   (gw),
				.rdata   (bank_q[b])
			);
		end
	endgenerate

	// Pending lanes shrink by the served set; replay until empty
	assign pending_next = accept ? req_mask :
		(pending_reg & ~served);

	always_comb begin
		case (state_reg)
			scratchpad_pkg::ST_IDLE: state_next = (accept && |req_mask) ?
				scratchpad_pkg::ST_BUSY : scratchpad_pkg::ST_IDLE;
			scratchpad_pkg::ST_BUSY: state_next = |pending_next ?
				scratchpad_pkg::ST_BUSY : scratchpad_pkg::ST_IDLE;
			default: state_next = scratchpad_pkg::ST_IDLE;
		endcase
	end

	// Whole window of two requests per lane latched at once
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg     <= scratchpad_pkg::ST_IDLE;
			pending_reg   <= '0;
			req_ready_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			pending_reg   <= pending_next;
			req_ready_reg <= (state_next == scratchpad_pkg::ST_IDLE);
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			write_reg <= 1'b0;
			addr_reg  <= '0;
			size_reg  <= '0;
			wdata_reg <= '0;
		end else if (accept) begin
			write_reg <= req_write;
			addr_reg  <= req_addr;
			size_reg  <= req_size;
			wdata_reg <= req_wdata;
		end
	end

	// Served lanes of each beat return two cycles later
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_valid_reg   <= 1'b0;
			s1_write_reg   <= 1'b0;
			s1_mask_reg    <= '0;
			resp_valid_reg <= 1'b0;
			resp_write_reg <= 1'b0;
			resp_lanes_reg <= '0;
			resp_rdata_reg <= '0;
		end else begin
			s1_valid_reg   <= |served;
			s1_write_reg   <= write_reg;
			s1_mask_reg    <= served;
			resp_valid_reg <= s1_valid_reg;
			resp_write_reg <= s1_write_reg;
			resp_lanes_reg <= s1_mask_reg;
			resp_rdata_reg <= route_data;
		end
	end

	// Stall share is stall_cycles over time_cycles
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wave_stall_reg <= 1'b0;
			stall_cnt_reg  <= '0;
			time_cnt_reg   <= '0;
		end else begin
			wave_stall_reg <= leftover;
			stall_cnt_reg  <= stall_cnt_reg + CNT_W'(leftover);
			time_cnt_reg   <= time_cnt_reg + 1'b1;
		end
	end

	assign req_ready    = req_ready_reg;
	assign resp_valid   = resp_valid_reg;
	assign resp_write   = resp_write_reg;
	assign resp_lanes   = resp_lanes_reg;
	assign resp_rdata   = resp_rdata_reg;
	assign wave_stall   = wave_stall_reg;
	assign stall_cycles = stall_cnt_reg;
	assign time_cycles  = time_cnt_reg;

	// Reads matching the lowest pending word, for broadcast check
	logic [SLOTS-1:0] low_word_hit;
	logic [WORD_W-1:0] low_word;
	always_comb begin
		low_word = '0;
		for (int i = SLOTS - 1; i >= 0; i--) begin
			if (pending_reg[i]) begin
				low_word = slot_word[i];
			end
		end
		for (int i = 0; i < SLOTS; i++) begin
			low_word_hit[i] = pending_reg[i] && slot_word[i] == low_word;
		end
	end

	a_bank_single_word: assert property (bank_bad == '0)
		else $error("bank served two different words");
	a_lowest_first: assert property (|pending_reg |->
		|(served & low_pend))
		else $error("lowest pending slot not served");
	a_progress_each: assert property (|pending_reg |=>
		((pending_reg & ~$past(pending_reg)) == '0) &&
		(pending_reg != $past(pending_reg)))
		else $error("no progress on pending lanes");
	a_read_broadcast: assert property (|pending_reg && !write_reg |->
		((low_word_hit & ~served) == '0))
		else $error("same word read not broadcast");
	a_resp_replay: assert property (|served |-> ##2
		(resp_valid && resp_lanes == $past(served, 2)))
		else $error("served lanes not returned two cycles later");
	a_accept_load: assert property (req_valid && req_ready && |req_mask
		|=> (pending_reg == $past(req_mask)) && !req_ready)
		else $error("window not latched on accept");
	a_stall_count: assert property (leftover |=>
		stall_cycles == $past(stall_cycles) + 1'b1)
		else $error("stall counter missed a conflict cycle");
	a_stall_quiet: assert property (!leftover |=> $stable(stall_cycles))
		else $error("stall counter moved without conflict");
	a_ready_idle: assert property (req_ready |-> pending_reg == '0)
		else $error("ready while lanes pending");

	c_conflict_run: cover property (leftover ##1 leftover);
	c_broadcast: cover property (!write_reg && $countones(served) > 1 &&
		!leftover);
	c_write_beat: cover property (resp_valid && resp_write);
	c_read_beat: cover property (resp_valid && !resp_write);
endmodule : banked_local_scratchpad
`default_nettype wire

/* File: verilog/scratchpad_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scratchpad_params.svh"
module scratchpad_bank #(
	parameter int DEPTH = 256,
	parameter int ROW_W = 8
) (
	input  wire logic                  sys_clk,
	input  wire logic                  en,
	input  wire logic                  we,
	input  wire logic [3:0]            be,
	input  wire logic [ROW_W-1:0]      row,
	input  wire logic [`SP_DATA_W-1:0] wdata,
	output logic      [`SP_DATA_W-1:0] rdata
);
	// No reset and no host port: contents persist
	logic [`SP_DATA_W-1:0] mem [DEPTH];

	always_ff @(posedge sys_clk) begin
		if (en && we) begin
			for (int i = 0; i < `SP_WORD_BYTES; i++) begin
				if (be[i]) begin
					mem[row][8*i +: 8] <= wdata[8*i +: 8];
				end
			end
		end else if (en) begin
			rdata <= mem[row];
		end
	end
endmodule : scratchpad_bank
`default_nettype wire

/* File: verilog/scratchpad_params.svh */
`ifndef SCRATCHPAD_PARAMS_SVH
`define SCRATCHPAD_PARAMS_SVH
`define SP_STORE_BYTES  32768
`define SP_BANKS_LARGE  32
`define SP_BANKS_SMALL  16
`define SP_WORD_BYTES   4
`define SP_OFS_W        2
`define SP_DATA_W       32
`define SP_LANES        16
`define SP_REQ_PER_LANE 2
`define SP_CNT_W        32
`define SP_SIZE_BYTE    2'h0
`define SP_SIZE_HALF    2'h1
`define SP_SIZE_WORD    2'h2
`define SP_BE_BYTE      4'h1
`define SP_BE_HALF      4'h3
`define SP_BE_WORD      4'hf
`endif

/* File: verilog/scratchpad_pkg.sv */
package scratchpad_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_BUSY = 2'h2
	} sp_state_t;
	typedef logic [1:0] access_size_t;
endpackage : scratchpad_pkg
